// [ppo_chan.sv]
/*
  One output channel's settings and its own start and width compare
  values, scaled from fractions to the block period every cycle.
  Assumes writes arrive already checked for pin conflicts.
*/
`timescale 1ns/1ps
`include "ppo_consts.svh"

module ppo_chan (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration writes
  input wire logic wr_pos,
  input wire logic wr_mode,
  input wire logic [31:0] wdata,
  // period of the owning block
  input wire logic [23:0] period,
  // settings and compare values
  output ppo_pkg::ppo_chan_cfg_t cfg,
  output logic [23:0] start,
  output logic [23:0] width
);

  ppo_pkg::ppo_chan_state_t q;
  ppo_pkg::ppo_chan_state_t d;
  logic [34:0] off_prod;
  logic [34:0] duty_prod;
  logic [10:0] off_in;
  logic [10:0] duty_in;

  always_comb begin
    d = q;
    off_in = wdata[`PPO_POS_OFF_LSB +: 11];
    duty_in = wdata[`PPO_POS_DUTY_LSB +: 11];
    if (wr_pos) begin
      d.cfg.ppm = wdata[`PPO_POS_PPM_BIT];
      d.cfg.offset = (off_in > `PPO_FRAC_FULL) ? `PPO_FRAC_FULL : off_in;
      d.cfg.duty = (duty_in > `PPO_FRAC_FULL) ? `PPO_FRAC_FULL : duty_in;
    end
    // an unknown mode code keeps the previous mode
    if (wr_mode && wdata[`PPO_MODE_LSB +: 3] <= 3'b101) begin
      d.cfg.mode = ppo_pkg::ppo_mode_t'(wdata[`PPO_MODE_LSB +: 3]);
    end
    if (wr_mode) begin
      d.cfg.lead_en = wdata[`PPO_LEAD_EN_BIT];
      d.cfg.lead_end = wdata[`PPO_LEAD_END_BIT];
      d.cfg.lead_src = wdata[`PPO_LEAD_SRC_LSB +: 2];
      d.cfg.trail_en = wdata[`PPO_TRAIL_EN_BIT];
      d.cfg.trail_end = wdata[`PPO_TRAIL_END_BIT];
      d.cfg.trail_src = wdata[`PPO_TRAIL_SRC_LSB +: 2];
    end
    // fractions rescale to any new period, so frequency changes keep them
    off_prod = period * q.cfg.offset;
    duty_prod = period * q.cfg.duty;
    if (!q.cfg.ppm) begin
      d.start = 24'h00_0000;
    end else if (off_prod[33:10] == 24'h00_0000) begin
      d.start = `PPO_MIN_START;
    end else begin
      d.start = off_prod[33:10];
    end
    d.width = duty_prod[33:10];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cfg = q.cfg;
  assign start = q.start;
  assign width = q.width;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_off_sat;
    wr_pos && off_in > `PPO_FRAC_FULL |=> q.cfg.offset == `PPO_FRAC_FULL;
  endproperty
  a_off_sat: assert property (p_off_sat)
    else $error("offset not saturated");

  property p_duty_sat;
    wr_pos && duty_in > `PPO_FRAC_FULL |=> q.cfg.duty == `PPO_FRAC_FULL;
  endproperty
  a_duty_sat: assert property (p_duty_sat)
    else $error("duty not saturated");

  property p_min_start;
    q.cfg.ppm && period != 24'h00_0000 |=> q.start != 24'h00_0000;
  endproperty
  a_min_start: assert property (p_min_start)
    else $error("position pulse starts at zero");

endmodule : ppo_chan

// [ppo_consts.svh]
/*
  Offsets, field positions, reset values and timing counts of the pulse
  position output block. Included by bare name; no logic here.
*/
`ifndef PPO_CONSTS_SVH
`define PPO_CONSTS_SVH

// clock and period range
`define PPO_CLK_HZ 25000000
`define PPO_FREQ_MIN_HZ 2
`define PPO_FREQ_MAX_HZ 50000
`define PPO_PERIOD_MAX (`PPO_CLK_HZ / `PPO_FREQ_MIN_HZ)
`define PPO_PERIOD_MIN (`PPO_CLK_HZ / `PPO_FREQ_MAX_HZ)
`define PPO_PERIOD_RST 24'h00_61a8

// register byte offsets
`define PPO_OFF_CTRL 8'h00
`define PPO_OFF_PINFN 8'h04
`define PPO_OFF_CONFLICT 8'h08
`define PPO_OFF_PHASE 8'h0c
`define PPO_OFF_PERIOD0 8'h10
`define PPO_OFF_PERIOD1 8'h14
`define PPO_CHAN_REGION 2'h1

// channel position word
`define PPO_POS_OFF_LSB 0
`define PPO_POS_DUTY_LSB 16
`define PPO_POS_PPM_BIT 31

// channel mode word
`define PPO_MODE_LSB 0
`define PPO_LEAD_EN_BIT 4
`define PPO_LEAD_END_BIT 5
`define PPO_LEAD_SRC_LSB 6
`define PPO_TRAIL_EN_BIT 8
`define PPO_TRAIL_END_BIT 9
`define PPO_TRAIL_SRC_LSB 10

// fractions are in 1/1024 of a period
`define PPO_FRAC_FULL 11'h400
`define PPO_MIN_START 24'h00_0001

// reset values
`define PPO_CTRL_RST 8'h00
`define PPO_PINFN_RST 8'h00
`define PPO_CONFLICT_RST 8'h00

`endif

// [ppo_load.sv]
/*
  Model of the high-current output drivers and their loads: resolves
  each channel's level and enable into sink, source or high impedance.
  Assumes the block's out / oe_n pair per channel, oe_n low = driving.
*/
`timescale 1ns/1ps

module ppo_load (
  // block side
  input wire logic [7:0] level,
  input wire logic [7:0] oe_n,
  // resolved pin states
  output ppo_pkg::ppo_drive_t [7:0] drive
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // unknown enable shows as sink-free float, never as a valid drive
      if (oe_n[i] !== 1'b0) begin
        drive[i] = ppo_pkg::drv_hiz;
      end else begin
        drive[i] = level[i] ? ppo_pkg::drv_source : ppo_pkg::drv_sink;
      end
    end
  end
endmodule : ppo_load

// [ppo_pkg.sv]
/*
  Types of the pulse position output block.
  Assumes ppo_consts.svh for all numeric constants except the mode and drive encodings, which are defined here.
*/
package ppo_pkg;

  typedef enum logic [2:0] {
    idle_hiz_pulse_sink = 3'b000,
    idle_hiz_pulse_source = 3'b001,
    idle_sink_pulse_source = 3'b010,
    idle_source_pulse_sink = 3'b011,
    idle_sink_pulse_hiz = 3'b100,
    idle_source_pulse_hiz = 3'b101
  } ppo_mode_t;

  typedef enum logic [1:0] {
    drv_sink = 2'b00,
    drv_source = 2'b01,
    drv_hiz = 2'b10
  } ppo_drive_t;

  typedef struct packed {
    logic ppm;
    logic [10:0] offset;
    logic [10:0] duty;
    ppo_mode_t mode;
    logic lead_en;
    logic lead_end;
    logic [1:0] lead_src;
    logic trail_en;
    logic trail_end;
    logic [1:0] trail_src;
  } ppo_chan_cfg_t;

  typedef struct packed {
    ppo_chan_cfg_t cfg;
    logic [23:0] start;
    logic [23:0] width;
  } ppo_chan_state_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] pinfn;
    logic [7:0] conflict;
    logic [1:0][23:0] period;
    logic [1:0][23:0] cnt;
    logic [7:0][23:0] s_fin;
    logic [7:0][23:0] e_fin;
    logic [7:0] phase;
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [31:0] prdata;
    logic pslverr;
  } ppo_state_t;

endpackage : ppo_pkg

// [ppo_top.sv]
/*
  Pulse position and width generator for eight high-current outputs in
  two blocks of four, with an APB register slave.
  Assumes pclk at 25 MHz, APB inputs synchronous to pclk, and external
  drivers that turn out / oe_n into sink, source or high impedance.
*/
//
// Contract
// - eight channels produce position pulses per request
// - idle and pulse phases drive any state
// - offset above full period saturates to full
// - zero position offset becomes one tick
// - duty above full period saturates to full
// - pulse ends at period end, never wraps
// - six idle/pulse state pairings supported
// - start edge may follow another channel's edge
// - end edge may follow another channel's edge
// - block period change keeps fractions
// - width change moves edges bound to it
// - pin conflicts reported as block bitmap
`timescale 1ns/1ps
`include "ppo_consts.svh"

module ppo_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // output drivers
  output logic [7:0] high_current_out,
  output logic [7:0] high_current_out_oe_n
);

  ////////////////////////////////////////////////////////////////////////

  ppo_pkg::ppo_state_t q;
  ppo_pkg::ppo_state_t d;

  ppo_pkg::ppo_chan_cfg_t [7:0] cfg;
  logic [7:0][23:0] ch_start;
  logic [7:0][23:0] ch_width;
  logic [7:0] wr_pos;
  logic [7:0] wr_mode;

  logic setup;
  logic access;
  logic chan_hit;
  logic [2:0] chan_idx;
  logic chan_mode_sel;
  logic mapped;
  logic [7:0] blk_pins;
  logic [7:0] conflict_map;
  logic chan_wr;
  logic accept;
  logic [31:0] rd;

  logic [7:0][2:0] lead_idx;
  logic [7:0][2:0] trail_idx;
  logic [7:0][23:0] lead_edge;
  logic [7:0][23:0] trail_edge;
  logic [7:0][23:0] s_new;
  logic [7:0][23:0] e_new;
  logic [7:0][24:0] e_sum;
  logic [7:0] pulse;
  logic [1:0][24:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////
  // drive state of a channel for its mode and phase

  function automatic ppo_pkg::ppo_drive_t drive_of(
    input ppo_pkg::ppo_mode_t mode,
    input logic active
  );
    ppo_pkg::ppo_drive_t r;
    case (mode)
      ppo_pkg::idle_hiz_pulse_sink: begin
        r = active ? ppo_pkg::drv_sink : ppo_pkg::drv_hiz;
      end
      ppo_pkg::idle_hiz_pulse_source: begin
        r = active ? ppo_pkg::drv_source : ppo_pkg::drv_hiz;
      end
      ppo_pkg::idle_sink_pulse_source: begin
        r = active ? ppo_pkg::drv_source : ppo_pkg::drv_sink;
      end
      ppo_pkg::idle_source_pulse_sink: begin
        r = active ? ppo_pkg::drv_sink : ppo_pkg::drv_source;
      end
      ppo_pkg::idle_sink_pulse_hiz: begin
        r = active ? ppo_pkg::drv_hiz : ppo_pkg::drv_sink;
      end
      ppo_pkg::idle_source_pulse_hiz: begin
        r = active ? ppo_pkg::drv_hiz : ppo_pkg::drv_source;
      end
      default: begin
        r = ppo_pkg::drv_hiz;
      end
    endcase
    return r;
  endfunction : drive_of

  ////////////////////////////////////////////////////////////////////////
  // channel settings, one instance per output

  for (genvar g = 0; g < 8; g++) begin : g_chan
    ppo_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .wr_pos(wr_pos[g]),
      .wr_mode(wr_mode[g]),
      .wdata(pwdata),
      .period(q.period[g / 4]),
      .cfg(cfg[g]),
      .start(ch_start[g]),
      .width(ch_width[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign chan_hit = (paddr[7:6] == `PPO_CHAN_REGION);
  assign chan_idx = paddr[5:3];
  assign chan_mode_sel = paddr[2];
  assign blk_pins = chan_idx[2] ? 8'hf0 : 8'h0f;
  // pins of the addressed block not set for pulse output
  assign conflict_map = blk_pins & ~q.pinfn;
  assign chan_wr = access && pwrite && chan_hit;
  assign accept = chan_wr && (conflict_map == 8'h00);

  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    if (chan_hit) begin
      if (chan_mode_sel) begin
        rd = {20'h0_0000, cfg[chan_idx].trail_src, cfg[chan_idx].trail_end,
              cfg[chan_idx].trail_en, cfg[chan_idx].lead_src,
              cfg[chan_idx].lead_end, cfg[chan_idx].lead_en, 1'b0,
              cfg[chan_idx].mode};
      end else begin
        rd = {cfg[chan_idx].ppm, 4'h0, cfg[chan_idx].duty, 5'h00,
              cfg[chan_idx].offset};
      end
    end else begin
      case (paddr)
        `PPO_OFF_CTRL: rd = {24'h00_0000, q.en};
        `PPO_OFF_PINFN: rd = {24'h00_0000, q.pinfn};
        `PPO_OFF_CONFLICT: rd = {24'h00_0000, q.conflict};
        `PPO_OFF_PHASE: rd = {24'h00_0000, q.phase};
        `PPO_OFF_PERIOD0: rd = {8'h00, q.period[0]};
        `PPO_OFF_PERIOD1: rd = {8'h00, q.period[1]};
        default: mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      wr_pos[c] = accept && (chan_idx == 3'(c)) && !chan_mode_sel;
      wr_mode[c] = accept && (chan_idx == 3'(c)) && chan_mode_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge selection; bound edges come from registered finals, so mutual
  // binding cannot form a combinational loop, at one cycle of lag

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      lead_idx[c] = {1'(c / 4), cfg[c].lead_src};
      trail_idx[c] = {1'(c / 4), cfg[c].trail_src};
      lead_edge[c] = cfg[c].lead_end ? q.e_fin[lead_idx[c]] : q.s_fin[lead_idx[c]];
      trail_edge[c] = cfg[c].trail_end ? q.e_fin[trail_idx[c]]
                                       : q.s_fin[trail_idx[c]];
      s_new[c] = cfg[c].lead_en ? lead_edge[c] : ch_start[c];
      e_sum[c] = {1'b0, s_new[c]} + {1'b0, ch_width[c]};
      if (cfg[c].trail_en) begin
        e_new[c] = trail_edge[c];
      end else begin
        e_new[c] = e_sum[c][23:0];
      end
      // a pulse never runs into the next period
      if (cfg[c].trail_en ? 1'b0 : e_sum[c][24]) begin
        e_new[c] = q.period[c / 4];
      end else if (e_new[c] > q.period[c / 4]) begin
        e_new[c] = q.period[c / 4];
      end
      pulse[c] = q.en[c] && q.pinfn[c] && (q.cnt[c / 4] >= q.s_fin[c])
                 && (q.cnt[c / 4] < q.e_fin[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    if (setup) begin
      d.prdata = pwrite ? 32'h0000_0000 : rd;
      d.pslverr = !mapped;
    end
    if (access && pwrite && !chan_hit) begin
      case (paddr)
        `PPO_OFF_CTRL: d.en = pwdata[7:0];
        `PPO_OFF_PINFN: d.pinfn = pwdata[7:0];
        `PPO_OFF_PERIOD0: d.period[0] = pwdata[23:0];
        `PPO_OFF_PERIOD1: d.period[1] = pwdata[23:0];
        default: d.en = q.en;
      endcase
    end
    if (chan_wr) begin
      d.conflict = conflict_map;
    end
    // one free-running counter per block
    for (int b = 0; b < 2; b++) begin
      cnt_nxt[b] = {1'b0, q.cnt[b]} + 25'h000_0001;
      if (cnt_nxt[b] >= {1'b0, q.period[b]}) begin
        d.cnt[b] = 24'h00_0000;
      end else begin
        d.cnt[b] = cnt_nxt[b][23:0];
      end
    end
    for (int c = 0; c < 8; c++) begin
      d.s_fin[c] = s_new[c];
      d.e_fin[c] = e_new[c];
      d.phase[c] = pulse[c];
      // disabled or foreign-function pins are left floating
      if (!q.en[c] || !q.pinfn[c]) begin
        d.oe_n[c] = 1'b1;
        d.out[c] = 1'b0;
      end else begin
        case (drive_of(cfg[c].mode, pulse[c]))
          ppo_pkg::drv_sink: begin
            d.oe_n[c] = 1'b0;
            d.out[c] = 1'b0;
          end
          ppo_pkg::drv_source: begin
            d.oe_n[c] = 1'b0;
            d.out[c] = 1'b1;
          end
          default: begin
            d.oe_n[c] = 1'b1;
            d.out[c] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.en <= `PPO_CTRL_RST;
      q.pinfn <= `PPO_PINFN_RST;
      q.conflict <= `PPO_CONFLICT_RST;
      q.period <= {`PPO_PERIOD_RST, `PPO_PERIOD_RST};
      q.oe_n <= 8'hff;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign pready = 1'b1;
  assign high_current_out = q.out;
  assign high_current_out_oe_n = q.oe_n;

  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  for (genvar g = 0; g < 8; g++) begin : g_chk
    property p_pulse_window;
      q.phase[g] |-> $past(q.cnt[g / 4]) < $past(q.e_fin[g])
                     && $past(q.cnt[g / 4]) >= $past(q.s_fin[g]);
    endproperty
    a_pulse_window: assert property (p_pulse_window)
      else $error("pulse outside its compare window");

    property p_drive;
      q.en[g] && q.pinfn[g] |=> q.oe_n[g] ==
        (drive_of($past(cfg[g].mode), q.phase[g]) == ppo_pkg::drv_hiz);
    endproperty
    a_drive: assert property (p_drive)
      else $error("output state does not match mode and phase");

    property p_source_level;
      q.en[g] && q.pinfn[g] && !q.oe_n[g] |-> q.out[g] ==
        (drive_of($past(cfg[g].mode), q.phase[g]) == ppo_pkg::drv_source);
    endproperty
    a_source_level: assert property (p_source_level)
      else $error("driven level does not match mode");

    property p_end_in_period;
      q.e_fin[g] <= $past(q.period[g / 4]);
    endproperty
    a_end_in_period: assert property (p_end_in_period)
      else $error("pulse end beyond period");

    property p_lead_bind;
      cfg[g].lead_en && !cfg[g].lead_end
        |=> q.s_fin[g] == $past(q.s_fin[lead_idx[g]]);
    endproperty
    a_lead_bind: assert property (p_lead_bind)
      else $error("bound start edge differs from source");

    property p_trail_bind;
      cfg[g].trail_en && cfg[g].trail_end
        && q.e_fin[trail_idx[g]] <= q.period[g / 4]
        |=> q.e_fin[g] == $past(q.e_fin[trail_idx[g]]);
    endproperty
    a_trail_bind: assert property (p_trail_bind)
      else $error("bound end edge differs from source");
  end

  for (genvar b = 0; b < 2; b++) begin : g_blk
    property p_counter_wrap;
      {1'b0, q.cnt[b]} + 25'h000_0001 >= {1'b0, q.period[b]}
        |=> q.cnt[b] == 24'h00_0000;
    endproperty
    a_counter_wrap: assert property (p_counter_wrap)
      else $error("block counter did not wrap");
  end

  property p_conflict;
    chan_wr && conflict_map != 8'h00
      |=> q.conflict == $past(conflict_map) && $stable(cfg);
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("conflicting request not refused and reported");

endmodule : ppo_top

// [pulse_position_output_block_tb.sv]
/*
  Self-checking bench: APB register traffic, then pulse counts per
  period observed through the driver model.
  Assumes ppo_top, ppo_load and ppo_consts.svh in the same folder.
*/
`timescale 1ns/1ps
`include "ppo_consts.svh"

module pulse_position_output_block_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, high_current_out, high_current_out_oe_n;
  logic [31:0] pwdata, prdata, q;
  logic err;
  ppo_pkg::ppo_drive_t [7:0] drv;
  int errors, num_checks, n;
  ppo_pkg::ppo_drive_t idle_t [6], puls_t [6];

  ppo_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_current_out(high_current_out),
    .high_current_out_oe_n(high_current_out_oe_n));
  ppo_load load (.level(high_current_out), .oe_n(high_current_out_oe_n), .drive(drv));

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] pos(input logic ppm, input logic [10:0] o,
                                      input logic [10:0] d);
    return {ppm, 4'h0, d, 5'h00, o};
  endfunction : pos

  // settle past a full period, then count cycles in state st over one period
  task automatic meas(input int ch, input ppo_pkg::ppo_drive_t st, input int p);
    repeat (p + 8) @(posedge pclk);
    n = 0;
    repeat (p) begin
      // sample mid-cycle, away from the edge that moves the outputs
      @(negedge pclk);
      if (drv[ch] === st) n++;
    end
  endtask : meas

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    idle_t = '{ppo_pkg::drv_hiz, ppo_pkg::drv_hiz, ppo_pkg::drv_sink,
      ppo_pkg::drv_source, ppo_pkg::drv_sink, ppo_pkg::drv_source};
    puls_t = '{ppo_pkg::drv_sink, ppo_pkg::drv_source, ppo_pkg::drv_source,
      ppo_pkg::drv_sink, ppo_pkg::drv_hiz, ppo_pkg::drv_hiz};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `PPO_OFF_PERIOD0, 0);
    chk(q, 32'h0000_61a8);
    // 500 cycles at 25 MHz is the 50 kHz top of the range
    apb(1, `PPO_OFF_PERIOD0, 32'h0000_01f4);
    apb(1, `PPO_OFF_PERIOD1, 32'h0000_01f4);
    apb(0, `PPO_OFF_CONFLICT, 0);
    chk({31'h0, err}, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1, 8'h40, pos(1, 256, 768));
    apb(0, `PPO_OFF_CONFLICT, 0);
    chk(q, 32'h0000_000f);
    apb(1, `PPO_OFF_PINFN, 32'h0000_00fd);
    apb(1, 8'h60, pos(0, 0, 512));
    apb(0, `PPO_OFF_CONFLICT, 0);
    chk(q, 32'h0000_0000);
    apb(1, 8'h48, pos(0, 0, 512));
    apb(0, `PPO_OFF_CONFLICT, 0);
    chk(q, 32'h0000_0002);
    apb(0, 8'hfc, 0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    apb(1, `PPO_OFF_PINFN, 32'h0000_00ff);
    apb(1, `PPO_OFF_CTRL, 32'h0000_00ff);
    // channel 0: idle sink, pulse source
    apb(1, 8'h44, 32'h0000_0002);
    apb(1, 8'h40, pos(1, 256, 768));
    meas(0, ppo_pkg::drv_source, 500);
    chk(n, 375);
    apb(1, 8'h40, pos(1, 256, 1000));
    meas(0, ppo_pkg::drv_source, 500);
    chk(n, 375);
    apb(1, 8'h40, pos(1, 2047, 1024));
    meas(0, ppo_pkg::drv_source, 500);
    chk(n, 0);
    apb(0, 8'h40, 0);
    chk(q, pos(1, 1024, 1024));
    apb(1, 8'h40, pos(1, 0, 1024));
    meas(0, ppo_pkg::drv_source, 500);
    chk(n, 499);
    apb(1, 8'h40, pos(0, 0, 2047));
    meas(0, ppo_pkg::drv_source, 500);
    chk(n, 500);
    apb(0, 8'h40, 0);
    chk(q, pos(0, 0, 1024));
    // channel 1 starts at channel 0's end edge, channel 2 ends there
    apb(1, 8'h40, pos(0, 0, 256));
    apb(1, 8'h4c, 32'h0000_0032);
    apb(1, 8'h48, pos(1, 0, 1024));
    meas(1, ppo_pkg::drv_source, 500);
    chk(n, 375);
    apb(1, 8'h40, pos(0, 0, 512));
    meas(1, ppo_pkg::drv_source, 500);
    chk(n, 250);
    apb(1, 8'h54, 32'h0000_0302);
    apb(1, 8'h50, pos(0, 0, 100));
    meas(2, ppo_pkg::drv_source, 500);
    chk(n, 250);
    // channel 3 starts at channel 0's start edge, not at its own one tick
    apb(1, 8'h5c, 32'h0000_0012);
    apb(1, 8'h58, pos(1, 0, 512));
    meas(3, ppo_pkg::drv_source, 500);
    chk(n, 250);
    apb(1, `PPO_OFF_PERIOD0, 32'h0000_03e8);
    meas(0, ppo_pkg::drv_source, 1000);
    chk(n, 500);
    apb(1, 8'h40, pos(0, 0, 256));
    meas(0, ppo_pkg::drv_source, 1000);
    chk(n, 250);
    // every state pairing on a block 1 channel at half duty
    for (int m = 0; m < 6; m++) begin
      apb(1, 8'h64, m);
      meas(4, puls_t[m], 500);
      chk(n, 250);
      meas(4, idle_t[m], 500);
      chk(n, 250);
    end
    // an unknown mode code must leave the last mode in place
    apb(1, 8'h64, 32'h0000_0006);
    apb(0, 8'h64, 0);
    chk(q, 32'h0000_0005);
    tally_and_finish();
  end
endmodule : pulse_position_output_block_tb
